// *** hdl/lfaf_top.sv ***
// limit fault alert flags: live status, sticky faults, alert enables and alert pin
// Contract
// - limit_status bit 7 shows power over max, bit 6 power under min.
// - limit_status bit 5 shows current over max, bit 4 under min.
// - limit_status bit 3 shows input voltage over max, bit 2 under min.
// - limit_status bit 1 shows aux input over max, bit 0 under min.
// - fault_history bits 7 and 6 remember power over and under events.
// - fault_history bits 5 and 4 remember current over and under events.
// - fault_history bits 3 and 2 remember input voltage over and under.
// - fault_history bits 1 and 0 remember aux input over and under.
// - enable bit 7 lets each finished conversion raise the alert.
// - enable bit 6 alerts when pin one turns active per its config.
// - enable bit 5 alerts when pin two turns active per its config.
// - enable bit 3 alerts on stuck-bus wake-up, only with auto wake set.
// - enable bit 2 alerts on energy register overflow.
// - enable bit 1 alerts on charge register overflow.
// - enable bit 0 alerts on time counter overflow.
// - threshold enable bits 7..0 gate the eight limit alerts one for one.
// - with control bit 5 set, reading fault_history clears it.
// - with control bit 7 set, being addressed releases the alert.
`timescale 1ns/100ps
`default_nettype none
module lfaf_top (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	output var  logic [7:0]  reg_rdata_o,
	output var  logic        reg_rvalid_o,
	input  wire logic        addressed_i,
	input  wire logic [7:0]  live_limit_i,
	input  wire logic        conv_done_i,
	input  wire logic        general_pin_one_i,
	input  wire logic        general_pin_two_i,
	input  wire logic        stuck_wake_i,
	input  wire logic        energy_ovf_i,
	input  wire logic        charge_ovf_i,
	input  wire logic        time_ovf_i,
	output logic             alert_o,
	output logic             general_pin_three_o,
	output logic             general_pin_three_oe_n_o,
	output logic             shutdown_o,
	output var  logic        accum_reset_o
);
	import lfaf_pkg::*;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	lfaf_core_if core ();

	logic [7:0] control_b;
	logic [7:0] threshold_alert_enable;
	logic [7:0] extra_alert_enable;
	logic [7:0] pin_config;
	logic [7:0] limit_status;
	lfaf_sel_e  wr_sel;
	lfaf_sel_e  rd_sel;
	logic       soft_reset;
	logic       fault_write;
	logic       fault_cor;
	logic       fault_op;

	assign wr_sel      = reg_wr_i ? lfaf_decode(reg_addr_i) : LFAF_SEL_NONE;
	assign rd_sel      = reg_rd_i ? lfaf_decode(reg_addr_i) : LFAF_SEL_NONE;
	// a reset-all write wipes every register except limit_status and live-held fault bits in the same cycle, itself included
	assign soft_reset  = (wr_sel == LFAF_SEL_CONTROL_B) &&
		(reg_wdata_i[LFAF_CB_RESET_HI:LFAF_CB_RESET_LO] == LFAF_CB_RESET_ALL);
	assign fault_write = (wr_sel == LFAF_SEL_FAULT);
	assign fault_cor   = (rd_sel == LFAF_SEL_FAULT) && control_b[LFAF_CB_CLR_ON_READ];
	assign fault_op    = fault_write || fault_cor;

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			control_b <= LFAF_RST_CONTROL_B;
		end else if (soft_reset) begin
			control_b <= LFAF_RST_CONTROL_B;
		end else if (wr_sel == LFAF_SEL_CONTROL_B) begin
			control_b <= reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			threshold_alert_enable <= LFAF_RST_THR_ALERT_EN;
		end else if (soft_reset) begin
			threshold_alert_enable <= LFAF_RST_THR_ALERT_EN;
		end else if (wr_sel == LFAF_SEL_THR_EN) begin
			threshold_alert_enable <= reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			extra_alert_enable <= LFAF_RST_EXTRA_ALERT_EN;
		end else if (soft_reset) begin
			extra_alert_enable <= LFAF_RST_EXTRA_ALERT_EN;
		end else if (wr_sel == LFAF_SEL_EXTRA_EN) begin
			extra_alert_enable <= reg_wdata_i & LFAF_MASK_EXTRA_ALERT;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_config <= LFAF_RST_PIN_CONFIG;
		end else if (soft_reset) begin
			pin_config <= LFAF_RST_PIN_CONFIG;
		end else if (wr_sel == LFAF_SEL_PIN_CFG) begin
			pin_config <= reg_wdata_i & LFAF_MASK_PIN_CONFIG;
		end
	end

	// accumulator reset is a command, not state: one pulse per write
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			accum_reset_o <= 1'b0;
		end else begin
			accum_reset_o <= (wr_sel == LFAF_SEL_CONTROL_B) &&
				(reg_wdata_i[LFAF_CB_RESET_HI:LFAF_CB_RESET_LO] == LFAF_CB_RESET_ACCUM);
		end
	end

	// ----------------------------------------------------------------
	// live status and edge history
	// ----------------------------------------------------------------
	logic pin_one_act;
	logic pin_two_act;
	logic pin_one_prev;
	logic pin_two_prev;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			limit_status <= LFAF_RST_LIMIT_STATUS;
		end else begin
			limit_status <= live_limit_i;
		end
	end

	assign pin_one_act = lfaf_pin_active(pin_config[LFAF_GP_ONE_HI:LFAF_GP_ONE_LO],
		general_pin_one_i);
	assign pin_two_act = lfaf_pin_active(pin_config[LFAF_GP_TWO_HI:LFAF_GP_TWO_LO],
		general_pin_two_i);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_one_prev <= 1'b0;
			pin_two_prev <= 1'b0;
		end else begin
			pin_one_prev <= pin_one_act;
			pin_two_prev <= pin_two_act;
		end
	end

	// ----------------------------------------------------------------
	// sticky faults and alert
	// ----------------------------------------------------------------
	// live conditions latch
	assign core.thr_set   = live_limit_i;
	assign core.fault_clr = (soft_reset || fault_cor) ? LFAF_ALL_ONES :
		fault_write ? ~reg_wdata_i : LFAF_ALL_ZEROS;

	// limit and pin events are edges: a lasting limit condition alerts once, so a bus clear sticks
	assign core.thr_evt = live_limit_i & ~limit_status;
	assign core.thr_en  = threshold_alert_enable;
	assign core.ext_evt = {conv_done_i, pin_one_act & ~pin_one_prev,
		pin_two_act & ~pin_two_prev, 1'b0,
		stuck_wake_i & control_b[LFAF_CB_AUTO_WAKE],
		energy_ovf_i, charge_ovf_i, time_ovf_i};
	assign core.ext_en  = extra_alert_enable;

	// clearing enabled faults releases it
	// a bit that its live condition holds set stays set, so it keeps the alert too
	assign core.alert_clr = (addressed_i && control_b[LFAF_CB_ALERT_CLR]) || soft_reset ||
		(fault_op && ((((core.fault & ~core.fault_clr) | core.thr_set) &
		threshold_alert_enable) == LFAF_ALL_ZEROS));

	lfaf_sticky_bank u_bank (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.core    (core.bank)
	);

	lfaf_alert_gate u_gate (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.core    (core.gate)
	);

	// ----------------------------------------------------------------
	// outputs and read port
	// ----------------------------------------------------------------
	assign alert_o             = core.alert;
	assign shutdown_o          = control_b[LFAF_CB_SHUTDOWN];
	assign general_pin_three_o = 1'b0;
	// open drain alert on pin three
	assign general_pin_three_oe_n_o = !(core.alert &&
		(pin_config[LFAF_GP_THREE_HI:LFAF_GP_THREE_LO] == LFAF_PIN_ALERT_OUT));

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o  <= LFAF_READ_UNMAPPED;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				case (rd_sel)
					LFAF_SEL_CONTROL_B: reg_rdata_o <= control_b;
					LFAF_SEL_THR_EN:    reg_rdata_o <= threshold_alert_enable;
					LFAF_SEL_STATUS:    reg_rdata_o <= limit_status;
					LFAF_SEL_FAULT:     reg_rdata_o <= core.fault;
					LFAF_SEL_EXTRA_EN:  reg_rdata_o <= extra_alert_enable;
					LFAF_SEL_PIN_CFG:   reg_rdata_o <= pin_config;
					default:            reg_rdata_o <= LFAF_READ_UNMAPPED;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb_main @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	logic any_masked;
	assign any_masked = |(core.thr_evt & threshold_alert_enable) |
		|(core.ext_evt & extra_alert_enable);

	chk_status_live: assert property (
		reg_rd_i && (rd_sel == LFAF_SEL_STATUS) |=> reg_rdata_o == $past(limit_status)
	) else $error("status read does not return live status");

	chk_status_track: assert property (
		$past(rst_n) |-> limit_status == $past(live_limit_i)
	) else $error("live status lags comparators by more than one cycle");

	chk_fault_capture: assert property (
		rst_n && (live_limit_i != LFAF_ALL_ZEROS) |=> (core.fault & $past(live_limit_i)) ==
			$past(live_limit_i)
	) else $error("live condition not latched into fault history");

	chk_fault_sticky: assert property (
		!fault_op && !soft_reset |=> (core.fault & $past(core.fault)) == $past(core.fault)
	) else $error("fault bit dropped without a clear");

	chk_cor_clear: assert property (
		fault_cor && !soft_reset && (live_limit_i == LFAF_ALL_ZEROS) |=>
			core.fault == LFAF_ALL_ZEROS
	) else $error("clear on read left fault bits set");

	chk_read_keep: assert property (
		reg_rd_i && (rd_sel == LFAF_SEL_FAULT) && !control_b[LFAF_CB_CLR_ON_READ] &&
			!reg_wr_i |=> core.fault == ($past(core.fault) | $past(live_limit_i))
	) else $error("plain read disturbed fault history");

	chk_addr_release: assert property (
		addressed_i && control_b[LFAF_CB_ALERT_CLR] && !any_masked |=> !alert_o
	) else $error("alert not released on addressing");

	chk_conv_alert: assert property (
		rst_n && conv_done_i && extra_alert_enable[LFAF_AL2_CONV_DONE] |=> alert_o
	) else $error("conversion done did not raise alert");

	chk_quiet_alert: assert property (
		!alert_o && !any_masked |=> !alert_o
	) else $error("alert rose without an enabled event");

	chk_alert_hold: assert property (
		alert_o && !core.alert_clr |=> alert_o [*1]
	) else $error("alert dropped without a clear");

	chk_pin3_drive: assert property (
		alert_o && (pin_config[LFAF_GP_THREE_HI:LFAF_GP_THREE_LO] == LFAF_PIN_ALERT_OUT)
			|-> !general_pin_three_oe_n_o && !general_pin_three_o
	) else $error("pin three not pulling low for alert");

	cov_conv_alert:  cover property (conv_done_i ##1 alert_o);
	cov_cor_clear:   cover property (fault_cor && core.fault != LFAF_ALL_ZEROS);
	cov_addr_clear:  cover property (alert_o && addressed_i ##1 !alert_o);
	cov_stuck_alert: cover property (stuck_wake_i && control_b[LFAF_CB_AUTO_WAKE] ##1 alert_o);

endmodule : lfaf_top
`default_nettype wire

// *** common/lfaf_pkg.sv ***
// constants, register map and decode helpers for the limit fault alert flags block
package lfaf_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] LFAF_ADDR_CONTROL_B      = 8'h01;
	localparam logic [7:0] LFAF_ADDR_THR_ALERT_EN   = 8'h02;
	localparam logic [7:0] LFAF_ADDR_LIMIT_STATUS   = 8'h03;
	localparam logic [7:0] LFAF_ADDR_FAULT_HISTORY  = 8'h04;
	localparam logic [7:0] LFAF_ADDR_EXTRA_ALERT_EN = 8'h32;
	localparam logic [7:0] LFAF_ADDR_PIN_CONFIG     = 8'h33;

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] LFAF_RST_CONTROL_B      = 8'h00;
	localparam logic [7:0] LFAF_RST_THR_ALERT_EN   = 8'h00;
	localparam logic [7:0] LFAF_RST_LIMIT_STATUS   = 8'h00;
	localparam logic [7:0] LFAF_RST_FAULT_HISTORY  = 8'h00;
	localparam logic [7:0] LFAF_RST_EXTRA_ALERT_EN = 8'h00;
	localparam logic [7:0] LFAF_RST_PIN_CONFIG     = 8'h00;
	localparam logic [7:0] LFAF_MASK_EXTRA_ALERT   = 8'hEF;
	localparam logic [7:0] LFAF_MASK_PIN_CONFIG    = 8'hFE;
	localparam logic [7:0] LFAF_READ_UNMAPPED      = 8'h00;
	localparam logic [7:0] LFAF_ALL_ONES           = 8'hFF;
	localparam logic [7:0] LFAF_ALL_ZEROS          = 8'h00;

	// ----------------------------------------------------------------
	// control_b field positions and codes
	// ----------------------------------------------------------------
	localparam int         LFAF_CB_ALERT_CLR    = 7;
	localparam int         LFAF_CB_SHUTDOWN     = 6;
	localparam int         LFAF_CB_CLR_ON_READ  = 5;
	localparam int         LFAF_CB_AUTO_WAKE    = 4;
	localparam int         LFAF_CB_RESET_HI     = 1;
	localparam int         LFAF_CB_RESET_LO     = 0;
	localparam logic [1:0] LFAF_CB_RESET_ALL    = 2'h3;
	localparam logic [1:0] LFAF_CB_RESET_ACCUM  = 2'h2;

	// ----------------------------------------------------------------
	// extra_alert_enable bit positions
	// ----------------------------------------------------------------
	localparam int LFAF_AL2_CONV_DONE = 7;
	localparam int LFAF_AL2_PIN_ONE   = 6;
	localparam int LFAF_AL2_PIN_TWO   = 5;
	localparam int LFAF_AL2_RESERVED  = 4;
	localparam int LFAF_AL2_STUCK     = 3;
	localparam int LFAF_AL2_ENERGY    = 2;
	localparam int LFAF_AL2_CHARGE    = 1;
	localparam int LFAF_AL2_TIME      = 0;

	// ----------------------------------------------------------------
	// pin_config fields and codes
	// ----------------------------------------------------------------
	localparam int         LFAF_GP_ONE_HI      = 7;
	localparam int         LFAF_GP_ONE_LO      = 6;
	localparam int         LFAF_GP_TWO_HI      = 5;
	localparam int         LFAF_GP_TWO_LO      = 4;
	localparam int         LFAF_GP_THREE_HI    = 3;
	localparam int         LFAF_GP_THREE_LO    = 2;
	localparam logic [1:0] LFAF_PIN_ACTIVE_LOW  = 2'h1;
	localparam logic [1:0] LFAF_PIN_ACTIVE_HIGH = 2'h0;
	localparam logic [1:0] LFAF_PIN_ALERT_OUT   = 2'h0;

	typedef enum {
		LFAF_SEL_NONE,
		LFAF_SEL_CONTROL_B,
		LFAF_SEL_THR_EN,
		LFAF_SEL_STATUS,
		LFAF_SEL_FAULT,
		LFAF_SEL_EXTRA_EN,
		LFAF_SEL_PIN_CFG
	} lfaf_sel_e;

	function automatic lfaf_sel_e lfaf_decode(input logic [7:0] addr);
		lfaf_sel_e sel;
		case (addr)
			LFAF_ADDR_CONTROL_B:      sel = LFAF_SEL_CONTROL_B;
			LFAF_ADDR_THR_ALERT_EN:   sel = LFAF_SEL_THR_EN;
			LFAF_ADDR_LIMIT_STATUS:   sel = LFAF_SEL_STATUS;
			LFAF_ADDR_FAULT_HISTORY:  sel = LFAF_SEL_FAULT;
			LFAF_ADDR_EXTRA_ALERT_EN: sel = LFAF_SEL_EXTRA_EN;
			LFAF_ADDR_PIN_CONFIG:     sel = LFAF_SEL_PIN_CFG;
			default:                  sel = LFAF_SEL_NONE;
		endcase
		return sel;
	endfunction : lfaf_decode

	// active level of a general pin input from its two-bit configuration
	function automatic logic lfaf_pin_active(input logic [1:0] cfg, input logic level);
		logic act;
		case (cfg)
			LFAF_PIN_ACTIVE_LOW:  act = ~level;
			LFAF_PIN_ACTIVE_HIGH: act = level;
			default:              act = 1'b0;
		endcase
		return act;
	endfunction : lfaf_pin_active

endpackage : lfaf_pkg

// *** common/lfaf_core_if.sv ***
// signals shared between the top, the sticky fault bank and the alert gate
`timescale 1ns/100ps
`default_nettype none
interface lfaf_core_if;
	logic [7:0] thr_set;
	logic [7:0] fault_clr;
	logic [7:0] fault;
	logic [7:0] thr_evt;
	logic [7:0] thr_en;
	logic [7:0] ext_evt;
	logic [7:0] ext_en;
	logic       alert_clr;
	logic       alert;

	modport bank (input thr_set, input fault_clr, output fault);
	modport gate (input thr_evt, input thr_en, input ext_evt, input ext_en,
		input alert_clr, output alert);
	modport top  (output thr_set, output fault_clr, output thr_evt, output thr_en,
		output ext_evt, output ext_en, output alert_clr, input fault, input alert);
endinterface : lfaf_core_if
`default_nettype wire

// *** hdl/lfaf_sticky_bank.sv ***
// eight sticky fault bits, set by live conditions and cleared by software
`timescale 1ns/100ps
`default_nettype none
module lfaf_sticky_bank (
	input  wire logic  clock_i,
	input  wire logic  rst_n_i,
	lfaf_core_if.bank  core
);
	import lfaf_pkg::*;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					core.fault[i] <= LFAF_RST_FAULT_HISTORY[i];
				end else if (core.thr_set[i]) begin
					core.fault[i] <= 1'b1;
				end else if (core.fault_clr[i]) begin
					core.fault[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : lfaf_sticky_bank
`default_nettype wire

// *** hdl/lfaf_alert_gate.sv ***
// alert latch: masked events set it, bus clear conditions release it
`timescale 1ns/100ps
`default_nettype none
module lfaf_alert_gate (
	input  wire logic  clock_i,
	input  wire logic  rst_n_i,
	lfaf_core_if.gate  core
);
	import lfaf_pkg::*;

	logic any_event;

	assign any_event = |(core.thr_evt & core.thr_en) | |(core.ext_evt & core.ext_en);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core.alert <= 1'b0;
		end else if (any_event) begin
			core.alert <= 1'b1;
		end else if (core.alert_clr) begin
			core.alert <= 1'b0;
		end
	end

endmodule : lfaf_alert_gate
`default_nettype wire

// *** bench/lfaf_host_model.sv ***
// bus host model: strobed register reads and writes plus the addressed pulse
`timescale 1ns/100ps
`default_nettype none
module lfaf_host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	output var  logic [7:0] addr_o,
	output var  logic       wr_o,
	output var  logic       rd_o,
	output var  logic [7:0] wdata_o,
	output var  logic       addressed_o
);
	initial begin
		addr_o      = 8'h00;
		wdata_o     = 8'h00;
		wr_o        = 1'h0;
		rd_o        = 1'h0;
		addressed_o = 1'h0;
	end

	// released lines show the inverse of the last value, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) #1;
		addr_o  = a;
		wdata_o = d;
		wr_o    = 1'h1;
		@(posedge clock_i) #1;
		wr_o    = 1'h0;
		addr_o  = ~a;
		wdata_o = ~d;
	endtask : wr

	// data without the valid flag is returned unknown so a compare fails
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i) #1;
		addr_o = a;
		rd_o   = 1'h1;
		@(posedge clock_i) #1;
		rd_o   = 1'h0;
		addr_o = ~a;
		d      = (rvalid_i === 1'h1) ? rdata_i : 8'hXX;
	endtask : rd

	task automatic hail();
		@(posedge clock_i) #1;
		addressed_o = 1'h1;
		@(posedge clock_i) #1;
		addressed_o = 1'h0;
	endtask : hail
endmodule : lfaf_host_model
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the limit fault alert flags block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import lfaf_pkg::*;
	typedef struct {logic [7:0] cb; logic [7:0] gp; logic [7:0] al2; logic [6:0] evt; logic exp;}
		lfaf_row_s;
	logic       clock_i = 1'h0;
	logic       rst_n;
	logic [7:0] addr, wdata, rdata, live, d;
	logic       wr, rd, rvalid, addressed, conv, pin1, pin2, stuck, energy, charge, tovf;
	logic       alert, pin3, oe_n, a1, a2, shut, acc_rst;
	int         n_fail = 0;
	int         checked = 0;
	// evt bits: conv, pin one, pin two, stuck wake, energy, charge, time
	lfaf_row_s  rows[15] = '{
		'{8'h80, 8'h00, 8'h80, 7'h40, 1'h1}, '{8'h80, 8'h00, 8'h7F, 7'h40, 1'h0},
		'{8'h80, 8'h00, 8'h40, 7'h20, 1'h1}, '{8'h80, 8'h40, 8'h40, 7'h20, 1'h1},
		'{8'h80, 8'hC0, 8'h40, 7'h20, 1'h0}, '{8'h80, 8'h10, 8'h20, 7'h10, 1'h1},
		'{8'h80, 8'h00, 8'hDF, 7'h10, 1'h0}, '{8'h90, 8'h00, 8'h08, 7'h08, 1'h1},
		'{8'h80, 8'h00, 8'h08, 7'h08, 1'h0}, '{8'h80, 8'h00, 8'h04, 7'h04, 1'h1},
		'{8'h80, 8'h00, 8'hFB, 7'h04, 1'h0}, '{8'h80, 8'h00, 8'h02, 7'h02, 1'h1},
		'{8'h80, 8'h00, 8'h01, 7'h01, 1'h1}, '{8'h80, 8'h00, 8'hFE, 7'h01, 1'h0},
		'{8'h80, 8'h00, 8'h20, 7'h10, 1'h1}};

	always #20 clock_i = ~clock_i;

	lfaf_host_model host_u (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wdata), .addressed_o(addressed));

	lfaf_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.addressed_i(addressed), .live_limit_i(live), .conv_done_i(conv),
		.general_pin_one_i(pin1), .general_pin_two_i(pin2), .stuck_wake_i(stuck),
		.energy_ovf_i(energy), .charge_ovf_i(charge), .time_ovf_i(tovf), .alert_o(alert),
		.general_pin_three_o(pin3), .general_pin_three_oe_n_o(oe_n), .shutdown_o(shut),
		.accum_reset_o(acc_rst));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// one-cycle event pulses; pins are left at the level the row asks for
	task automatic fire(input logic [6:0] e);
		@(posedge clock_i) #1;
		{conv, stuck, energy, charge, tovf} = {e[6], e[3:0]};
		pin1 = e[5] ? a1 : ~a1;
		pin2 = e[4] ? a2 : ~a2;
		@(posedge clock_i) #1;
		{conv, stuck, energy, charge, tovf} = 5'h00;
	endtask : fire

	task automatic edge_live(input logic [7:0] v);
		@(posedge clock_i) #1;
		live = v;
		@(posedge clock_i) #1;
	endtask : edge_live

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'h0;
		live  = 8'h00;
		{conv, pin1, pin2, stuck, energy, charge, tovf} = 7'h00;
		{a1, a2} = 2'h3;
		repeat (3) @(posedge clock_i);
		#1 rst_n = 1'h1;
		repeat (4) @(posedge clock_i);
		host_u.rd(LFAF_ADDR_LIMIT_STATUS, d);
		check("status reset", d, LFAF_RST_LIMIT_STATUS);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		check("fault reset", d, LFAF_RST_FAULT_HISTORY);
		host_u.rd(LFAF_ADDR_EXTRA_ALERT_EN, d);
		check("extra enable reset", d, LFAF_RST_EXTRA_ALERT_EN);
		check("pin three idle", oe_n, 8'h01);
		foreach (rows[i]) begin
			a1   = (rows[i].gp[7:6] != LFAF_PIN_ACTIVE_LOW);
			a2   = (rows[i].gp[5:4] != LFAF_PIN_ACTIVE_LOW);
			pin1 = ~a1;
			pin2 = ~a2;
			host_u.wr(LFAF_ADDR_PIN_CONFIG, rows[i].gp);
			host_u.wr(LFAF_ADDR_CONTROL_B, rows[i].cb);
			host_u.wr(LFAF_ADDR_EXTRA_ALERT_EN, rows[i].al2);
			host_u.hail();
			check("alert released", alert, 8'h00);
			fire(rows[i].evt);
			check("event alert", alert, rows[i].exp);
			check("alert pin", oe_n, !rows[i].exp);
		end
		// the walking bit exposes swapped status positions
		for (int i = 0; i < 8; i++) begin
			edge_live(8'h01 << i);
			host_u.rd(LFAF_ADDR_LIMIT_STATUS, d);
			check("live status", d, 8'h01 << i);
		end
		edge_live(8'h00);
		host_u.rd(LFAF_ADDR_LIMIT_STATUS, d);
		check("status clear", d, 8'h00);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		check("fault sticky", d, 8'hFF);
		host_u.wr(LFAF_ADDR_FAULT_HISTORY, 8'h0F);
		host_u.wr(LFAF_ADDR_LIMIT_STATUS, 8'hFF);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		check("fault write zero", d, 8'h0F);
		host_u.rd(8'h10, d);
		check("unmapped read", d, LFAF_READ_UNMAPPED);
		host_u.wr(LFAF_ADDR_THR_ALERT_EN, 8'h01);
		host_u.hail();
		edge_live(8'h02);
		check("masked limit", alert, 8'h00);
		edge_live(8'h03);
		check("enabled limit", alert, 8'h01);
		edge_live(8'h00);
		host_u.wr(LFAF_ADDR_CONTROL_B, 8'h00);
		host_u.hail();
		check("alert holds", alert, 8'h01);
		host_u.wr(LFAF_ADDR_PIN_CONFIG, 8'h04);
		check("pin three other use", oe_n, 8'h01);
		host_u.wr(LFAF_ADDR_PIN_CONFIG, 8'h00);
		check("pin three alert", {oe_n, pin3}, 8'h00);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		check("plain read keeps", d, 8'h0F);
		host_u.wr(LFAF_ADDR_CONTROL_B, 8'h20);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		check("clearing read data", d, 8'h0F);
		@(posedge clock_i) #1;
		check("alert after clear", alert, 8'h00);
		host_u.rd(LFAF_ADDR_FAULT_HISTORY, d);
		check("cleared on read", d, 8'h00);
		host_u.wr(LFAF_ADDR_CONTROL_B, 8'h62);
		check("shutdown on", shut, 8'h01);
		check("accum reset pulse", acc_rst, 8'h01);
		@(posedge clock_i) #1;
		check("accum reset ends", acc_rst, 8'h00);
		host_u.wr(LFAF_ADDR_EXTRA_ALERT_EN, 8'h80);
		fire(7'h40);
		host_u.wr(LFAF_ADDR_CONTROL_B, 8'h03);
		check("soft reset alert", alert, 8'h00);
		check("soft reset shutdown", shut, 8'h00);
		host_u.rd(LFAF_ADDR_EXTRA_ALERT_EN, d);
		check("soft reset regs", d, 8'h00);
		// hardware reset mid-run drops alert and shutdown at once, without a clock edge
		host_u.wr(LFAF_ADDR_EXTRA_ALERT_EN, 8'h80);
		fire(7'h40);
		host_u.wr(LFAF_ADDR_CONTROL_B, 8'h40);
		check("alert before reset", alert, 8'h01);
		@(posedge clock_i) #1;
		rst_n = 1'h0;
		#1;
		check("reset alert", alert, 8'h00);
		check("reset pin three", oe_n, 8'h01);
		check("reset shutdown", shut, 8'h00);
		repeat (3) @(posedge clock_i);
		#1 rst_n = 1'h1;
		repeat (4) @(posedge clock_i);
		host_u.rd(LFAF_ADDR_EXTRA_ALERT_EN, d);
		check("reset extra enable", d, LFAF_RST_EXTRA_ALERT_EN);
		print_verdict();
	end

	// the whole run needs about 265 cycles; this allows over thirty times that
	initial begin
		#400000;
		n_fail++;
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
